// ---- verilog/rsp_core.sv ----
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/1ps
`include "rsp_cfg.svh"
// What this block does
// - Push: pointer rises by one, then PC stored in the new entry
// - Pop only lowers the pointer; the older entry becomes top
// - Software writes to the three top bytes change the addressed entry
// - Pointer register: full bit 7, underflow bit 6, bit 5 zero, pointer 4-0
// - Full flag set when stack becomes full or a push overflows
// - Underflow flag set when popping an empty stack
// - Flags clear at reset, stay set until software clears, never set by software
// - With overflow reset enabled, flag is set and device reset asserted in the same cycle
// - With overflow reset disabled, flag is set and no device reset
// - One shadow each of status, working, bank loaded on interrupt vector
// - Shadows are neither readable nor writable by software
// - Fast interrupt return restores the three shadow values
// - Fast call saves the three registers; fast return restores them
// - A nested interrupt overwrites the single shadow level
// - Table pointer holds a byte address; latch moves one byte per transfer
// - Clock divided by four into phases Q1 to Q4 forming one cycle
// - PC increments in Q1; fetched opcode latched in Q4
// - Execute: operands read in Q2, destinations written in Q4
// - Fetch overlaps execute; PC change flushes the prefetched opcode
// - Stack is 31 entries of 21 bits; pointer zero has no storage
// - Full flag set after 31 pushes without a pop
// - Overflow reset disabled: extra pushes keep pointer 31, keep last entry
// - Pop of empty stack keeps pointer zero; a pop with branch also loads zero into PC
module rsp_core
    import rsp_pkg::*;
#(
    parameter int DEPTH = `RSP_DEPTH
) (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        cfgResetEnable,
    input  wire rsp_bus_s    bus,
    output logic [7:0]       rdata,
    input  wire rsp_cmd_s    cmd,
    input  wire rsp_ctx_s    ctxLive,
    input  wire logic [15:0] progData,
    input  wire logic        tblRead,
    input  wire logic        tblWrite,
    input  wire logic [7:0]  tblReadByte,
    output logic [7:0]       tblWriteByte,
    output logic [20:0]      progAddr,
    output logic [20:0]      tblAddr,
    output logic [15:0]      fetchedOpcode,
    output logic             opcodeValid,
    output rsp_phase_e       phase,
    output logic             readStrobe,
    output logic             writeStrobe,
    output rsp_ctx_s         ctxRestore,
    output logic             ctxRestoreValid,
    output logic             deviceReset
);
    // Refuse a depth that the 5-bit pointer cannot serve
    if (DEPTH != `RSP_DEPTH) begin : g_depth_check
        $error("rsp_core: DEPTH must equal the 5-bit pointer range");
    end

    // ----------------------------------------
    // Storage and state
    // ----------------------------------------
    logic [20:0] stackMem [1:DEPTH];
    rsp_state_s  st;
    rsp_state_s  next_st;
    logic        stkWe;
    logic [4:0]  stkWa;
    logic [20:0] stkWd;
    logic [20:0] topEntry;
    logic        sysReset;
    logic        exec_push;
    logic        exec_pop;

    assign topEntry = (st.ptr == `RSP_PTR_RST) ? `RSP_RESET_VEC : stackMem[st.ptr];
    assign sysReset = reset || st.stackReset;
    // Command slots watched by the checks
    assign exec_push = (st.phase == RSP_Q4) && st.opValid && cmd.push;
    assign exec_pop  = (st.phase == RSP_Q4) && st.opValid && !cmd.push && cmd.pop;

    // Replace one byte of the top entry
    function automatic logic [20:0] setByte(input logic [20:0] v, input logic [1:0] sel,
                                            input logic [7:0] b);
        logic [20:0] r;
        r = v;
        unique case (sel)
            2'h0: r[7:0] = b;
            2'h1: r[15:8] = b;
            default: r[20:16] = b[4:0];
        endcase
        return r;
    endfunction

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic exec;
        logic [4:0] sp;
        exec = 1'b0;
        sp = 5'h00;
        next_st = st;
        stkWe = 1'b0;
        stkWa = st.ptr;
        stkWd = st.pc;
        next_st.stackReset = 1'b0;
        next_st.restoreValid = 1'b0;
        next_st.rdata = 8'h00;
        next_st.phase = rsp_phase_e'(st.phase + 2'h1);
        exec = (st.phase == RSP_Q4) && st.opValid;
        // Step the PC in Q1; a flushed cycle fetches the new PC unstepped
        if (st.phase == RSP_Q1 && st.opValid) begin
            next_st.pc = 21'(st.pc + `RSP_PC_STEP);
        end
        if (st.phase == RSP_Q4) begin
            next_st.opcode = progData;
            next_st.opValid = 1'b1;
        end
        // Software register writes
        if (bus.wr) begin
            unique case (bus.addr)
                `RSP_OFF_PTR: begin
                    next_st.ptr = bus.wdata[4:0];
                    if (!bus.wdata[`RSP_BIT_FULL]) next_st.fullFlag = 1'b0;
                    if (!bus.wdata[`RSP_BIT_UNDER]) next_st.underFlag = 1'b0;
                end
                `RSP_OFF_TOPL, `RSP_OFF_TOPH, `RSP_OFF_TOPU: begin
                    if (st.ptr != `RSP_PTR_RST) begin
                        stkWe = 1'b1;
                        stkWd = setByte(topEntry, 2'(bus.addr - `RSP_OFF_TOPL), bus.wdata);
                    end
                end
                `RSP_OFF_PCLO: begin
                    next_st.pc = {st.pc[20:8], bus.wdata[7:1], 1'b0};
                    next_st.opValid = 1'b0;
                end
                `RSP_OFF_TBLPL: next_st.table_byte_pointer[7:0] = bus.wdata;
                `RSP_OFF_TBLPH: next_st.table_byte_pointer[15:8] = bus.wdata;
                `RSP_OFF_TBLPU: next_st.table_byte_pointer[20:16] = bus.wdata[4:0];
                `RSP_OFF_TBLLAT: next_st.tblLatch = bus.wdata;
                default: ;
            endcase
        end
        // Software register reads; shadows have no address
        if (bus.rd) begin
            unique case (bus.addr)
                `RSP_OFF_PTR: next_st.rdata = {st.fullFlag, st.underFlag, 1'b0, st.ptr};
                `RSP_OFF_TOPL: next_st.rdata = topEntry[7:0];
                `RSP_OFF_TOPH: next_st.rdata = topEntry[15:8];
                `RSP_OFF_TOPU: next_st.rdata = {3'h0, topEntry[20:16]};
                `RSP_OFF_PCLO: next_st.rdata = st.pc[7:0];
                `RSP_OFF_TBLPL: next_st.rdata = st.table_byte_pointer[7:0];
                `RSP_OFF_TBLPH: next_st.rdata = st.table_byte_pointer[15:8];
                `RSP_OFF_TBLPU: next_st.rdata = {3'h0, st.table_byte_pointer[20:16]};
                `RSP_OFF_TBLLAT: next_st.rdata = st.tblLatch;
                default: next_st.rdata = 8'h00;
            endcase
        end
        // Table transfer, one byte each
        if (tblRead) begin
            next_st.tblLatch = tblReadByte;
        end
        // Stack and flow commands at end of the execute cycle
        if (exec) begin
            if (cmd.push) begin
                if (st.ptr == `RSP_PTR_MAX) begin
                    next_st.fullFlag = 1'b1;
                    next_st.stackReset = st.resetEnable;
                end else begin
                    sp = 5'(st.ptr + 5'h01);
                    next_st.ptr = sp;
                    stkWe = 1'b1;
                    stkWa = sp;
                    stkWd = st.pc;
                    if (sp == `RSP_PTR_MAX) begin
                        next_st.fullFlag = 1'b1;
                        next_st.stackReset = st.resetEnable;
                    end
                end
            end else if (cmd.pop) begin
                if (st.ptr == `RSP_PTR_RST) begin
                    next_st.underFlag = 1'b1;
                    next_st.stackReset = st.resetEnable;
                    if (cmd.branch) next_st.pc = `RSP_RESET_VEC;
                end else begin
                    next_st.ptr = 5'(st.ptr - 5'h01);
                    if (cmd.branch) next_st.pc = topEntry;
                end
            end
            if (cmd.intVector || cmd.callFast) begin
                next_st.shadow = ctxLive;
            end
            if (cmd.retFast) begin
                next_st.restore = st.shadow;
                next_st.restoreValid = 1'b1;
            end
            if (cmd.branch && !cmd.pop) begin
                next_st.pc = cmd.target;
            end
            if (cmd.branch) begin
                next_st.opValid = 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Registers; flags survive the stack reset
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sysReset) begin
            st.phase <= RSP_Q1;
            st.ptr <= `RSP_PTR_RST;
            st.pc <= `RSP_RESET_VEC;
            st.opcode <= 16'h0000;
            st.opValid <= 1'b0;
            st.shadow <= '0;
            st.restore <= '0;
            st.restoreValid <= 1'b0;
            st.table_byte_pointer <= 21'h000000;
            st.tblLatch <= 8'h00;
            st.stackReset <= 1'b0;
            st.rdata <= 8'h00;
            if (reset) begin
                st.fullFlag <= 1'b0;
                st.underFlag <= 1'b0;
                st.resetEnable <= cfgResetEnable;
            end else begin
                st.fullFlag <= st.fullFlag;
                st.underFlag <= st.underFlag;
                st.resetEnable <= st.resetEnable;
            end
        end else begin
            st <= next_st;
        end
    end

    // Stack memory write port
    always_ff @(posedge sys_clk) begin
        if (stkWe && !sysReset) begin
            stackMem[stkWa] <= stkWd;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign rdata           = st.rdata;
    assign progAddr        = st.pc;
    assign tblAddr         = st.table_byte_pointer;
    assign tblWriteByte    = st.tblLatch;
    assign fetchedOpcode   = st.opcode;
    assign opcodeValid     = st.opValid;
    assign phase           = st.phase;
    assign readStrobe      = (st.phase == RSP_Q2) && st.opValid;
    assign writeStrobe     = (st.phase == RSP_Q4) && st.opValid;
    assign ctxRestore      = st.restore;
    assign ctxRestoreValid = st.restoreValid;
    assign deviceReset     = st.stackReset;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_phase_cycle: assert property (@(posedge sys_clk) disable iff (sysReset)
        st.phase == RSP_Q4 |=> st.phase == RSP_Q1)
        else $error("phase did not wrap to Q1");
    chk_pc_step: assert property (@(posedge sys_clk) disable iff (sysReset)
        (st.phase == RSP_Q1 && st.opValid && !bus.wr)
        |=> st.pc == 21'($past(st.pc) + 21'h2))
        else $error("pc did not step in Q1");
    chk_push_ptr: assert property (@(posedge sys_clk) disable iff (sysReset)
        (exec_push && st.ptr < 5'h1E && !bus.wr) |=> st.ptr == 5'($past(st.ptr) + 5'h1))
        else $error("push did not advance pointer");
    chk_pop_ptr: assert property (@(posedge sys_clk) disable iff (sysReset)
        (exec_pop && st.ptr != 5'h0 && !bus.wr) |=> st.ptr == 5'($past(st.ptr) - 5'h1))
        else $error("pop did not lower pointer");
    chk_under_set: assert property (@(posedge sys_clk) disable iff (sysReset)
        (exec_pop && st.ptr == 5'h0) |=> st.underFlag && st.ptr == 5'h0)
        else $error("underflow not flagged");
    chk_full_hold: assert property (@(posedge sys_clk) disable iff (sysReset)
        (exec_push && st.ptr == 5'h1F && !bus.wr) |=> st.fullFlag && st.ptr == 5'h1F)
        else $error("overflow push moved pointer");
    // Device reset pulse, then the flag still standing
    sequence seq_reset_keeps_flag;
        deviceReset ##1 st.underFlag;
    endsequence
    sequence seq_full_then_clear;
        deviceReset ##1 (st.fullFlag && st.ptr == 5'h00);
    endsequence
    chk_reset_follow: assert property (@(posedge sys_clk) disable iff (reset)
        (exec_pop && st.ptr == 5'h0 && st.resetEnable) |=> seq_reset_keeps_flag)
        else $error("underflow reset missing");
    chk_full_reset: assert property (@(posedge sys_clk) disable iff (reset)
        (exec_push && st.ptr == 5'h1E && st.resetEnable && !bus.wr)
        |=> seq_full_then_clear)
        else $error("full reset missing");
    chk_no_reset: assert property (@(posedge sys_clk) disable iff (sysReset)
        !st.resetEnable |-> !deviceReset)
        else $error("reset while disabled");
    chk_fast_ret: assert property (@(posedge sys_clk) disable iff (sysReset)
        (st.phase == RSP_Q4 && st.opValid && cmd.retFast)
        |=> ctxRestoreValid && ctxRestore == $past(st.shadow))
        else $error("fast return mismatch");
    chk_flush: assert property (@(posedge sys_clk) disable iff (sysReset)
        (st.phase == RSP_Q4 && st.opValid && cmd.branch) |=> !opcodeValid [*4])
        else $error("prefetch not flushed");
endmodule // rsp_core

// ---- verilog/rsp_cfg.svh ----
`ifndef RSP_CFG_SVH
`define RSP_CFG_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RSP_OFF_PTR      4'h0
`define RSP_OFF_TOPL     4'h1
`define RSP_OFF_TOPH     4'h2
`define RSP_OFF_TOPU     4'h3
`define RSP_OFF_PCLO     4'h4
`define RSP_OFF_TBLPL    4'h5
`define RSP_OFF_TBLPH    4'h6
`define RSP_OFF_TBLPU    4'h7
`define RSP_OFF_TBLLAT   4'h8
// ----------------------------------------
// Field positions and sizes
// ----------------------------------------
`define RSP_BIT_FULL     7
`define RSP_BIT_UNDER    6
`define RSP_DEPTH        31
`define RSP_PC_W         21
`define RSP_PTR_W        5
`define RSP_PTR_MAX      5'h1F
`define RSP_PTR_RST      5'h00
`define RSP_PC_STEP      21'h000002
`define RSP_RESET_VEC    21'h000000
// ----------------------------------------
// Phase codes
// ----------------------------------------
`define RSP_PHASES       4
`endif

// ---- verilog/rsp_pkg.sv ----
package rsp_pkg;
    // Quarter phases of one instruction cycle
    typedef enum logic [1:0] {
        RSP_Q1 = 2'b00,
        RSP_Q2 = 2'b01,
        RSP_Q3 = 2'b10,
        RSP_Q4 = 2'b11
    } rsp_phase_e;

    // Stack and flow commands from the decoder, one per instruction cycle
    typedef struct packed {
        logic       push;
        logic       pop;
        logic       callFast;
        logic       retFast;
        logic       intVector;
        logic       branch;
        logic [20:0] target;
    } rsp_cmd_s;

    // Status, working and bank select registers
    typedef struct packed {
        logic [7:0] status;
        logic [7:0] work;
        logic [3:0] bank;
    } rsp_ctx_s;

    // Register port
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } rsp_bus_s;

    // Whole block state except the stack entries
    typedef struct packed {
        rsp_phase_e  phase;
        logic [4:0]  ptr;
        logic        fullFlag;
        logic        underFlag;
        logic [20:0] pc;
        logic [15:0] opcode;
        logic        opValid;
        rsp_ctx_s    shadow;
        rsp_ctx_s    restore;
        logic        restoreValid;
        logic [20:0] table_byte_pointer;
        logic [7:0]  tblLatch;
        logic        stackReset;
        logic        resetEnable;
        logic [7:0]  rdata;
    } rsp_state_s;
endpackage

// ---- testbench/rsp_prog_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Program memory seen by the core
// ----------------------------------------
module rsp_prog_model
    import rsp_pkg::*;
(
    input  wire logic [20:0] progAddr,
    input  wire logic [20:0] tblAddr,
    output logic      [15:0] progData,
    output logic      [7:0]  tblReadByte
);
    // Word content follows the word address, so every fetch is traceable
    assign progData = progAddr[16:1] ^ 16'hA5C3;
    // One byte per table transfer, taken from the byte address
    assign tblReadByte = tblAddr[7:0] ^ tblAddr[15:8] ^ 8'h5A;
endmodule // rsp_prog_model

// ---- testbench/rsp_core_test.sv ----
`timescale 1ns/1ps
`include "rsp_cfg.svh"
module rsp_core_test;
    import rsp_pkg::*;
    localparam rsp_cmd_s PUSH_C = '{push: 1'b1, default: '0};
    localparam rsp_cmd_s POP_C  = '{pop: 1'b1, default: '0};
    localparam rsp_cmd_s RET_C  = '{pop: 1'b1, branch: 1'b1, target: 21'h000100, default: '0};
    localparam rsp_cmd_s RETF_C = '{pop: 1'b1, branch: 1'b1, retFast: 1'b1, default: '0};
    localparam rsp_cmd_s INT_C  = '{intVector: 1'b1, default: '0};
    localparam rsp_cmd_s CALL_C = '{push: 1'b1, callFast: 1'b1, branch: 1'b1, default: '0};
    localparam rsp_cmd_s BR_C   = '{branch: 1'b1, target: 21'h000400, default: '0};
    logic        sys_clk, reset, cfgResetEnable, tblRead, rstSeen;
    rsp_bus_s    bus;
    rsp_cmd_s    cmd;
    rsp_ctx_s    ctxLive, ctxRestore, lastRestore;
    logic [7:0]  rdata, tblReadByte, tblWriteByte, rd8;
    logic [15:0] progData, fetchedOpcode;
    logic [20:0] progAddr, tblAddr, pcSeen, first, got;
    logic        opcodeValid, readStrobe, writeStrobe, ctxRestoreValid, deviceReset;
    rsp_phase_e  phase;
    int          numErrors, checked, restoreCount;

    rsp_core u_dut (.sys_clk(sys_clk), .reset(reset), .cfgResetEnable(cfgResetEnable),
        .bus(bus), .rdata(rdata), .cmd(cmd), .ctxLive(ctxLive), .progData(progData),
        .tblRead(tblRead), .tblWrite(1'b0), .tblReadByte(tblReadByte),
        .tblWriteByte(tblWriteByte), .progAddr(progAddr), .tblAddr(tblAddr),
        .fetchedOpcode(fetchedOpcode), .opcodeValid(opcodeValid), .phase(phase),
        .readStrobe(readStrobe), .writeStrobe(writeStrobe), .ctxRestore(ctxRestore),
        .ctxRestoreValid(ctxRestoreValid), .deviceReset(deviceReset));
    rsp_prog_model u_mem (.progAddr(progAddr), .tblAddr(tblAddr), .progData(progData),
        .tblReadByte(tblReadByte));

    // ----------------------------------------
    // Clock, monitors and shared tasks
    // ----------------------------------------
    // 200 MHz system clock
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // Remember device resets and restored contexts
    always @(posedge sys_clk) begin
        if (deviceReset === 1'b1) rstSeen <= 1'b1;
        if (ctxRestoreValid === 1'b1) begin
            lastRestore <= ctxRestore;
            restoreCount <= restoreCount + 1;
        end
    end
    task automatic check(input logic [31:0] g, input logic [31:0] e, input string what);
        checked++;
        if (g !== e) begin
            numErrors++;
            $display("MISMATCH %0t %s got %0h exp %0h", $time, what, g, e);
        end
    endtask
    task automatic doReset();
        reset <= 1'b1;
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        rstSeen <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic wrReg(input logic [3:0] a, input logic [7:0] d);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge sys_clk);
        bus.wr <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rdReg(input logic [3:0] a, output logic [7:0] d);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge sys_clk);
        bus.rd <= 1'b0;
        #1 d = rdata;
        @(posedge sys_clk);
    endtask
    task automatic rdChk(input logic [3:0] a, input logic [7:0] e);
        rdReg(a, rd8);
        check(rd8, e, "register read");
    endtask
    task automatic rdTop(output logic [20:0] v);
        logic [7:0] l, h, u;
        rdReg(`RSP_OFF_TOPL, l);
        rdReg(`RSP_OFF_TOPH, h);
        rdReg(`RSP_OFF_TOPU, u);
        v = {u[4:0], h, l};
    endtask
    // Hold a command over one whole execute cycle, Q1 to Q4
    task automatic doCmd(input rsp_cmd_s c);
        int n;
        n = 0;
        #1;
        while (!(phase === RSP_Q4 && opcodeValid === 1'b1) && n < 40) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        if (n == 40) check(0, 1, "no execute slot");
        @(posedge sys_clk);
        cmd <= c;
        repeat (3) @(posedge sys_clk);
        #1 pcSeen = progAddr;
        @(posedge sys_clk);
        cmd <= '0;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic testRegs();
        rdChk(`RSP_OFF_PTR, 8'h00);
        rdChk(4'hF, 8'h00);
        wrReg(`RSP_OFF_PTR, 8'hFF);
        rdChk(`RSP_OFF_PTR, 8'h1F);
    endtask
    task automatic testPushPop();
        doCmd(PUSH_C);
        first = pcSeen;
        rdChk(`RSP_OFF_PTR, 8'h01);
        rdTop(got);
        check(got, first, "pushed pc");
        doCmd(PUSH_C);
        wrReg(`RSP_OFF_TOPL, 8'h34);
        wrReg(`RSP_OFF_TOPH, 8'h12);
        wrReg(`RSP_OFF_TOPU, 8'h1F);
        rdTop(got);
        check(got, 21'h1F1234, "top write");
        doCmd(POP_C);
        rdChk(`RSP_OFF_PTR, 8'h01);
        rdTop(got);
        check(got, first, "older top");
    endtask
    task automatic testUnderflow();
        logic seen;
        seen = 1'b0;
        doCmd(RET_C);
        repeat (12) begin
            @(posedge sys_clk);
            #1;
            if (progAddr === `RSP_RESET_VEC) seen = 1'b1;
        end
        @(posedge sys_clk);
        check(seen, 1, "pc zero on underflow");
        rdChk(`RSP_OFF_PTR, 8'h40);
        doCmd(PUSH_C);
        rdChk(`RSP_OFF_PTR, 8'h41);
        wrReg(`RSP_OFF_PTR, 8'hC1);
        rdChk(`RSP_OFF_PTR, 8'h41);
        wrReg(`RSP_OFF_PTR, 8'h01);
        rdChk(`RSP_OFF_PTR, 8'h01);
        check(rstSeen, 0, "no device reset");
    endtask
    task automatic testFull();
        logic [20:0] last;
        for (int i = 1; i <= 31; i++) begin
            doCmd(PUSH_C);
            if (i == 30) rdChk(`RSP_OFF_PTR, 8'h1E);
        end
        rdChk(`RSP_OFF_PTR, 8'h9F);
        rdTop(last);
        doCmd(PUSH_C);
        rdChk(`RSP_OFF_PTR, 8'h9F);
        rdTop(got);
        check(got, last, "last entry kept");
        check(rstSeen, 0, "no device reset");
    endtask
    task automatic testShadow();
        ctxLive <= 20'h11223;
        doCmd(INT_C);
        ctxLive <= 20'h45678;
        doCmd(RETF_C);
        repeat (4) @(posedge sys_clk);
        check(restoreCount, 1, "restore pulse");
        check(lastRestore, 20'h11223, "int restore");
        doCmd(INT_C);
        ctxLive <= 20'h9ABCD;
        doCmd(INT_C);
        ctxLive <= 20'h00000;
        doCmd(RETF_C);
        repeat (4) @(posedge sys_clk);
        check(lastRestore, 20'h9ABCD, "nested restore");
        ctxLive <= 20'h5A5A5;
        doCmd(CALL_C);
        ctxLive <= 20'h0F0F0;
        doCmd(RETF_C);
        repeat (4) @(posedge sys_clk);
        check(lastRestore, 20'h5A5A5, "call restore");
    endtask
    task automatic testPhases();
        rsp_phase_e p;
        logic [20:0] pc0;
        #1 p = phase;
        pc0 = progAddr;
        repeat (16) begin
            @(posedge sys_clk);
            #1 p = rsp_phase_e'(p + 2'd1);
            check(phase, p, "phase order");
            check(readStrobe, phase === RSP_Q2 && opcodeValid === 1'b1, "operand read");
            check(writeStrobe, phase === RSP_Q4 && opcodeValid === 1'b1, "dest write");
        end
        check(progAddr, pc0 + 4 * `RSP_PC_STEP, "pc step");
        @(posedge sys_clk);
    endtask
    task automatic testBranch();
        logic flushed, fetched;
        flushed = 1'b0;
        fetched = 1'b0;
        doCmd(BR_C);
        repeat (16) begin
            @(posedge sys_clk);
            #1;
            if (opcodeValid === 1'b0) flushed = 1'b1;
            if (fetchedOpcode === (16'h0200 ^ 16'hA5C3)) fetched = 1'b1;
        end
        @(posedge sys_clk);
        check(flushed, 1, "prefetch flushed");
        check(fetched, 1, "target fetched");
        wrReg(`RSP_OFF_PCLO, 8'h40);
        check(progAddr[7:0], 8'h40, "computed jump");
    endtask
    task automatic testTable();
        wrReg(`RSP_OFF_TBLPL, 8'h3C);
        wrReg(`RSP_OFF_TBLPH, 8'h12);
        wrReg(`RSP_OFF_TBLPU, 8'h05);
        check(tblAddr, 21'h05123C, "table pointer");
        tblRead <= 1'b1;
        @(posedge sys_clk);
        tblRead <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rdChk(`RSP_OFF_TBLLAT, 8'h3C ^ 8'h12 ^ 8'h5A);
        check(tblWriteByte, 8'h3C ^ 8'h12 ^ 8'h5A, "latch out");
    endtask
    // Overflow reset enabled: underflow, then the 31st push, each reset the device
    task automatic testResetEnable();
        doCmd(RET_C);
        repeat (2) @(posedge sys_clk);
        check(rstSeen, 1, "underflow reset");
        rdChk(`RSP_OFF_PTR, 8'h40);
        wrReg(`RSP_OFF_PTR, 8'h00);
        rstSeen <= 1'b0;
        for (int i = 1; i <= 31; i++) doCmd(PUSH_C);
        repeat (2) @(posedge sys_clk);
        check(rstSeen, 1, "full reset");
        rdChk(`RSP_OFF_PTR, 8'h80);
    endtask

    // ----------------------------------------
    // Sequence, watchdog and verdict
    // ----------------------------------------
    task automatic end_sim();
        $display("errors %0d checks %0d", numErrors, checked);
        if (numErrors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Main sequence, each scenario from a fresh reset except the branch and table tests
    initial begin
        reset = 1'b1;
        cfgResetEnable = 1'b0;
        tblRead = 1'b0;
        bus = '0;
        cmd = '0;
        ctxLive = '0;
        rstSeen = 1'b0;
        numErrors = 0;
        checked = 0;
        restoreCount = 0;
        doReset();
        testRegs();
        doReset();
        testPushPop();
        doReset();
        testUnderflow();
        doReset();
        testFull();
        doReset();
        testShadow();
        doReset();
        testPhases();
        testBranch();
        testTable();
        cfgResetEnable <= 1'b1;
        doReset();
        testResetEnable();
        end_sim();
    end
    // Cuts a hang short well beyond the expected run time
    initial begin
        #60000;
        numErrors++;
        end_sim();
    end
endmodule // rsp_core_test
